// ---- rtl/adc_pkg.sv ----
// Constants and types shared by both ends of the serial converter link.
// Assumes one 40 MHz system clock on each end; no other clocks.
`default_nettype none
package adc_pkg;
  localparam int unsigned CLK_MHZ       = 40;
  localparam int unsigned DATA_W        = 12;
  localparam int unsigned FIFO_DEPTH    = 32;

  // Falling-edge counts within a frame
  localparam logic [4:0]  EDGE_ZERO     = 5'h00;
  localparam logic [4:0]  EDGE_ONE      = 5'h01;
  localparam logic [4:0]  EDGE_SAMPLED  = 5'h03;
  localparam logic [4:0]  EDGE_ABORT    = 5'h0a;
  localparam logic [4:0]  EDGE_LAST     = 5'h10;

  // Serial clock made by the controller: half period in system cycles
  localparam int unsigned SCLK_HALF_CYC = 8;
  localparam logic [3:0]  HALF_LAST     = 4'(SCLK_HALF_CYC - 1);
  localparam logic [3:0]  HALF_ZERO     = 4'h0;
  // Toggle counts: 32 toggles make 16 pulses; 18 toggles leave 9 falls done
  localparam logic [5:0]  TOG_ZERO      = 6'h00;
  localparam logic [5:0]  TOG_LAST      = 6'h20;
  localparam logic [5:0]  TOG_ABORT_MAX = 6'h12;

  // Least chip-select high time between frames
  localparam int unsigned GAP_NS        = 1000;
  localparam int unsigned GAP_CYC       = (GAP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [5:0]  GAP_LAST      = 6'(GAP_CYC - 1);
  localparam logic [5:0]  GAP_ZERO      = 6'h00;

  // Received word: the first zero shows before any rise, so 2 zeros,
  // 12 data bits, 1 zero, then the released (pulled-up) bit
  localparam int unsigned RX_W          = 16;
  localparam int unsigned RX_DATA_LSB   = 2;
  localparam int unsigned RX_DATA_MSB   = 13;

  localparam logic [11:0] DATA_RST      = 12'h000;
  localparam logic [11:0] DATA_POISON   = 12'h000;
  localparam logic [15:0] RX_RST        = 16'h0000;
  localparam logic        PIN_IDLE      = 1'b1;

  typedef enum logic [2:0] {
    DEV_OFF     = 3'b001,
    DEV_SAMPLE  = 3'b010,
    DEV_CONVERT = 3'b100
  } dev_state_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'b001,
    H_RUN  = 3'b010,
    H_GAP  = 3'b100
  } host_state_t;
endpackage
`default_nettype wire

// ---- rtl/adc_link_if.sv ----
// Serial link between the converter end and its controller.
// Resolves the three-state data pin; an idle pin is pulled high.
`timescale 1ns/1ps
`default_nettype none
interface adc_link_if;
  logic cs_n;
  logic sclk;
  logic sdo;
  logic sdo_oe;
  logic sdo_line;

  assign sdo_line = sdo_oe ? sdo : 1'b1;

  modport dev (
    input  cs_n,
    input  sclk,
    output sdo,
    output sdo_oe
  );

  modport host (
    output cs_n,
    output sclk,
    input  sdo_line
  );
endinterface
`default_nettype wire

// ---- rtl/adc_dev.sv ----
// Converter end: wakes on chip select, samples, shifts the result out.
// Assumes the controller drives chip select and serial clock slowly
// enough that both survive two-flop sampling on clk_i.
`timescale 1ns/1ps
`default_nettype none
module adc_dev (
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  adc_link_if.dev                     link,
  input  wire logic [adc_pkg::DATA_W-1:0] analog_input_i,
  output logic                        awake_o,
  output logic                        full_on_o,
  output logic                        sample_o,
  output logic                        done_o,
  output logic                        aborted_o,
  output logic                        invalid_o
);
  import adc_pkg::*;

  // Pin synchronisers and edge history
  logic cs_s1_r;
  logic cs_s2_r;
  logic cs_d_r;
  logic sck_s1_r;
  logic sck_s2_r;
  logic sck_d_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cs_s1_r  <= PIN_IDLE;
      cs_s2_r  <= PIN_IDLE;
      cs_d_r   <= PIN_IDLE;
      sck_s1_r <= PIN_IDLE;
      sck_s2_r <= PIN_IDLE;
      sck_d_r  <= PIN_IDLE;
    end else begin
      cs_s1_r  <= link.cs_n;
      cs_s2_r  <= cs_s1_r;
      cs_d_r   <= cs_s2_r;
      sck_s1_r <= link.sclk;
      sck_s2_r <= sck_s1_r;
      sck_d_r  <= sck_s2_r;
    end
  end

  wire logic cs_fall;
  wire logic cs_rise;
  wire logic sck_fall;
  wire logic cs_low;

  assign cs_low   = ~cs_s2_r;
  assign cs_fall  = cs_d_r & ~cs_s2_r;
  assign cs_rise  = ~cs_d_r & cs_s2_r;
  assign sck_fall = sck_d_r & ~sck_s2_r & cs_low;

  dev_state_t        state_r;
  dev_state_t        state_nxt;
  logic [4:0]        edge_cnt_r;
  logic [4:0]        edge_cnt_nxt;
  logic [DATA_W-1:0] shift_r;
  logic [DATA_W-1:0] shift_nxt;
  logic              sdo_r;
  logic              sdo_nxt;
  logic              oe_r;
  logic              oe_nxt;
  logic              poison_r;
  logic              poison_nxt;
  logic              sample_r;
  logic              sample_nxt;
  logic              done_r;
  logic              done_nxt;
  logic              abort_r;
  logic              abort_nxt;

  wire logic [4:0]        edge_inc;
  wire logic [DATA_W-1:0] sample_val;
  wire logic              early_rise;

  assign edge_inc   = edge_cnt_r + EDGE_ONE;
  assign sample_val = poison_r ? DATA_POISON : analog_input_i;
  assign early_rise = cs_rise && (edge_cnt_r < EDGE_ABORT);

  always_comb begin
    state_nxt    = state_r;
    edge_cnt_nxt = edge_cnt_r;
    shift_nxt    = shift_r;
    sdo_nxt      = sdo_r;
    oe_nxt       = oe_r;
    poison_nxt   = poison_r;
    sample_nxt   = 1'b0;
    done_nxt     = 1'b0;
    abort_nxt    = 1'b0;
    unique case (state_r)
      DEV_OFF: begin
        if (cs_fall) begin
          state_nxt    = DEV_SAMPLE;
          edge_cnt_nxt = EDGE_ZERO;
          sdo_nxt      = 1'b0;
          oe_nxt       = 1'b1;
        end
      end
      DEV_SAMPLE: begin
        if (cs_rise) begin
          state_nxt  = DEV_OFF;
          oe_nxt     = 1'b0;
          poison_nxt = 1'b1;
          abort_nxt  = 1'b1;
        end else if (sck_fall) begin
          edge_cnt_nxt = edge_inc;
          sdo_nxt      = 1'b0;
          if (edge_inc == EDGE_SAMPLED) begin
            state_nxt  = DEV_CONVERT;
            sample_nxt = 1'b1;
            sdo_nxt    = sample_val[DATA_W-1];
            shift_nxt  = {sample_val[DATA_W-2:0], 1'b0};
          end
        end
      end
      DEV_CONVERT: begin
        if (cs_rise) begin
          // early rise aborts, later rise just ends
          state_nxt = DEV_OFF;
          oe_nxt    = 1'b0;
          if (early_rise) begin
            poison_nxt = 1'b1;
            abort_nxt  = 1'b1;
          end
        end else if (sck_fall) begin
          edge_cnt_nxt = edge_inc;
          if (edge_inc == EDGE_LAST) begin
            state_nxt  = DEV_OFF;
            oe_nxt     = 1'b0;
            done_nxt   = 1'b1;
            poison_nxt = 1'b0;
          end else begin
            // new bit just after the fall
            sdo_nxt   = shift_r[DATA_W-1];
            shift_nxt = {shift_r[DATA_W-2:0], 1'b0};
          end
        end
      end
      default: begin
        state_nxt = DEV_OFF;
        oe_nxt    = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r    <= DEV_OFF;
      edge_cnt_r <= EDGE_ZERO;
      shift_r    <= DATA_RST;
      sdo_r      <= 1'b0;
      oe_r       <= 1'b0;
      poison_r   <= 1'b0;
      sample_r   <= 1'b0;
      done_r     <= 1'b0;
      abort_r    <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      edge_cnt_r <= edge_cnt_nxt;
      shift_r    <= shift_nxt;
      sdo_r      <= sdo_nxt;
      oe_r       <= oe_nxt;
      poison_r   <= poison_nxt;
      sample_r   <= sample_nxt;
      done_r     <= done_nxt;
      abort_r    <= abort_nxt;
    end
  end

  // output driven only inside a frame
  assign link.sdo    = sdo_r;
  assign link.sdo_oe = oe_r;

  // powered only while a frame runs
  assign awake_o   = (state_r != DEV_OFF);
  assign full_on_o = (state_r == DEV_CONVERT);
  assign sample_o  = sample_r;
  assign done_o    = done_r;
  assign aborted_o = abort_r;
  assign invalid_o = poison_r;
endmodule
`default_nettype wire

// ---- rtl/adc_host.sv ----
// Controller end: makes chip select and serial clock, collects results
// into a FIFO. Assumes the reader drains the FIFO through valid/ready.
`timescale 1ns/1ps
`default_nettype none
module adc_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             resetn_i,
  input  wire logic             wr_valid_i,
  output logic                  wr_ready_o,
  input  wire logic [WIDTH-1:0] wr_data_i,
  output logic                  rd_valid_o,
  input  wire logic             rd_ready_i,
  output logic [WIDTH-1:0]      rd_data_o
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW:0]      wr_ptr_r;
  logic [AW:0]      rd_ptr_r;

  wire logic full;
  wire logic empty;
  wire logic push;
  wire logic pop;

  assign full       = (wr_ptr_r[AW] != rd_ptr_r[AW]) && (wr_ptr_r[AW-1:0] == rd_ptr_r[AW-1:0]);
  assign empty      = (wr_ptr_r == rd_ptr_r);
  assign push       = wr_valid_i && !full;
  assign pop        = rd_ready_i && !empty;
  assign wr_ready_o = !full;
  assign rd_valid_o = !empty;
  assign rd_data_o  = mem_r[rd_ptr_r[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r[AW-1:0]] <= wr_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      wr_ptr_r <= wr_ptr_r + (AW+1)'(push);
      rd_ptr_r <= rd_ptr_r + (AW+1)'(pop);
    end
  end
endmodule

module adc_host (
  input  wire logic                   clk_i,
  input  wire logic                   resetn_i,
  adc_link_if.host                    link,
  input  wire logic                   start_i,
  output logic                        start_ready_o,
  input  wire logic                   abort_i,
  output logic                        busy_o,
  output logic                        result_valid_o,
  input  wire logic                   result_ready_i,
  output logic [adc_pkg::DATA_W-1:0]  result_data_o
);
  import adc_pkg::*;

  logic sd_s1_r;
  logic sd_s2_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sd_s1_r <= PIN_IDLE;
      sd_s2_r <= PIN_IDLE;
    end else begin
      sd_s1_r <= link.sdo_line;
      sd_s2_r <= sd_s1_r;
    end
  end

  host_state_t     state_r;
  logic            cs_n_r;
  logic            sclk_r;
  logic [3:0]      half_r;
  logic [5:0]      tog_r;
  logic [5:0]      gap_r;
  logic [RX_W-1:0] rx_r;
  logic            discard_r;
  logic            push_r;

  wire logic fifo_ready;
  wire logic go;
  wire logic tick;
  wire logic finish;
  wire logic cut;

  // Start only with room for the result, so a push is never refused
  assign go     = (state_r == H_IDLE) && start_i && fifo_ready;
  assign tick   = (state_r == H_RUN) && (half_r == HALF_LAST);
  assign finish = tick && (tog_r == TOG_LAST);
  assign cut    = (state_r == H_RUN) && abort_i && !finish;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r   <= H_IDLE;
      cs_n_r    <= 1'b1;
      sclk_r    <= 1'b1;
      half_r    <= HALF_ZERO;
      tog_r     <= TOG_ZERO;
      gap_r     <= GAP_ZERO;
      rx_r      <= RX_RST;
      discard_r <= 1'b0;
      push_r    <= 1'b0;
    end else begin
      push_r <= 1'b0;
      unique case (state_r)
        H_IDLE: begin
          if (go) begin
            state_r <= H_RUN;
            cs_n_r  <= 1'b0;
            half_r  <= HALF_ZERO;
            tog_r   <= TOG_ZERO;
          end
        end
        H_RUN: begin
          half_r <= half_r + 4'h1;
          if (cut || finish) begin
            state_r <= H_GAP;
            cs_n_r  <= 1'b1;
            sclk_r  <= 1'b1;
            gap_r   <= GAP_ZERO;
            // an abort by toggle 18 drops the next finished frame
            if (cut && tog_r <= TOG_ABORT_MAX) begin
              discard_r <= 1'b1;
            end else if (finish) begin
              discard_r <= 1'b0;
              push_r    <= !discard_r;
            end
          end else if (tick) begin
            half_r <= HALF_ZERO;
            tog_r  <= tog_r + 6'h01;
            sclk_r <= ~sclk_r;
            if (!sclk_r) begin
              rx_r <= {rx_r[RX_W-2:0], sd_s2_r};
            end
          end
        end
        H_GAP: begin
          // hold select high at least 1 us
          gap_r <= gap_r + 6'h01;
          if (gap_r == GAP_LAST) begin
            state_r <= H_IDLE;
          end
        end
        default: begin
          state_r <= H_IDLE;
          cs_n_r  <= 1'b1;
        end
      endcase
    end
  end

  adc_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i      (clk_i),
    .resetn_i   (resetn_i),
    .wr_valid_i (push_r),
    .wr_ready_o (fifo_ready),
    .wr_data_i  (rx_r[RX_DATA_MSB:RX_DATA_LSB]),
    .rd_valid_o (result_valid_o),
    .rd_ready_i (result_ready_i),
    .rd_data_o  (result_data_o)
  );

  assign link.cs_n     = cs_n_r;
  assign link.sclk     = sclk_r;
  assign start_ready_o = (state_r == H_IDLE) && fifo_ready;
  assign busy_o        = (state_r != H_IDLE);
endmodule
`default_nettype wire

// ---- tb/adc_monitor.sv ----
// Checker for the converter link: framing, wire order and gap timing.
// Sees only link signals on the shared clock; instanced beside the link.
`timescale 1ns/1ps
`default_nettype none
module adc_monitor (
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic sdo,
  input wire logic sdo_oe,
  input wire logic sdo_line
);
  import adc_pkg::*;
  logic       sclk_q_r;
  logic [4:0] falls_r;
  logic [5:0] high_r;
  wire        sclk_fall;

  assign sclk_fall = sclk_q_r & ~sclk;

  // Falls seen in this frame, and select-high time (saturating)
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_q_r <= 1'b1;
      falls_r  <= 5'h00;
      high_r   <= 6'h3f;
    end else begin
      sclk_q_r <= sclk;
      falls_r  <= cs_n ? 5'h00 : falls_r + {4'h0, sclk_fall};
      high_r   <= !cs_n ? 6'h00 : high_r + {5'h00, high_r != 6'h3f};
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  chk_drive_needs_select: assert property ($rose(sdo_oe) |-> !$past(cs_n, 2))
    else $error("data driven without select");
  chk_wake_on_fall: assert property ($fell(cs_n) |-> ##[2:5] (sdo_oe && !sdo_line))
    else $error("no wake after select fall");
  chk_leading_zeros: assert property (sdo_oe && !cs_n && falls_r < 5'h03 |-> !sdo_line)
    else $error("leading bit not zero");
  chk_tristate_last: assert property (sclk_fall && falls_r == 5'h0f |-> ##[1:5] !sdo_oe)
    else $error("output not released after last fall");
  chk_drive_held: assert property (sdo_oe && !cs_n && falls_r < 5'h0f |=> sdo_oe)
    else $error("output released early");
  chk_off_when_high: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("output driven while deselected");
  chk_clock_idle: assert property (cs_n |-> sclk)
    else $error("clock moves while deselected");
  chk_select_gap: assert property ($fell(cs_n) |-> high_r >= 6'(GAP_CYC))
    else $error("select high time too short");
  chk_pulse_count: assert property (!cs_n |-> falls_r <= 5'h10)
    else $error("more than sixteen clocks in a frame");
  chk_bit_on_fall: assert property (sdo_oe && $past(sdo_oe) && !cs_n && $changed(sdo_line) |-> !sclk)
    else $error("data changed while clock high");

  cov_full_frame: cover property (sclk_fall && falls_r == 5'h0f);
  cov_early_rise: cover property ($rose(cs_n) && falls_r == 5'h09);
  cov_next_frame: cover property ($fell(cs_n) && high_r != 6'h3f);
endmodule
`default_nettype wire

// ---- tb/serial_adc_readout_powerdown_tb_top.sv ----
// Bench for the converter link: both ends joined, results read back.
// Assumes design files and the link monitor are compiled first.
`timescale 1ns/1ps
`default_nettype none
module serial_adc_readout_powerdown_tb_top;
  import adc_pkg::*;
  typedef struct packed {
    logic [11:0] analog_input;
    logic [15:0] exp;
  } row_t;
  row_t              rows [6] = '{'{12'h000, 16'h1000}, '{12'hfff, 16'h1fff}, '{12'h800, 16'h1800},
                                  '{12'h001, 16'h1001}, '{12'ha5a, 16'h1a5a}, '{12'h5a5, 16'h15a5}};
  logic              clk_i, resetn_i, start_i, abort_i, result_ready_i;
  logic              start_ready_o, busy_o, result_valid_o, awake_o, full_on_o;
  logic              sample_o, done_o, aborted_o, invalid_o, done_seen, sample_seen, ab_seen;
  logic [DATA_W-1:0] analog_input_i, result_data_o;
  int                err_count, tests_run, n;

  adc_link_if link ();
  adc_dev u_adc_dev (.clk_i(clk_i), .resetn_i(resetn_i), .link(link.dev), .analog_input_i(analog_input_i),
    .awake_o(awake_o), .full_on_o(full_on_o), .sample_o(sample_o), .done_o(done_o), .aborted_o(aborted_o),
    .invalid_o(invalid_o));
  adc_host u_adc_host (.clk_i(clk_i), .resetn_i(resetn_i), .link(link.host), .start_i(start_i),
    .start_ready_o(start_ready_o), .abort_i(abort_i), .busy_o(busy_o), .result_valid_o(result_valid_o),
    .result_ready_i(result_ready_i), .result_data_o(result_data_o));
  adc_monitor u_adc_monitor (.clk_i(clk_i), .resetn_i(resetn_i), .cs_n(link.cs_n), .sclk(link.sclk),
    .sdo(link.sdo), .sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  // Latch one-cycle pulses so tasks can look at them later
  always @(posedge clk_i) begin
    if (done_o === 1'b1) done_seen <= 1'b1;
    if (sample_o === 1'b1) sample_seen <= 1'b1;
    if (aborted_o === 1'b1) ab_seen <= 1'b1;
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clk_i);
    #2;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  function automatic logic sig(input int k);
    return k == 0 ? busy_o : result_valid_o;
  endfunction

  task automatic wait_for(input int k, input logic lvl, input int lim);
    int i;
    i = 0;
    while (sig(k) !== lvl) begin
      tick(1);
      i++;
      if (i > lim) begin
        check("wait", 16'(sig(k)), 16'(lvl));
        summarize();
      end
    end
  endtask

  task automatic launch;
    start_i = 1'b1;
    wait_for(0, 1'b1, 20);
    start_i = 1'b0;
  endtask

  task automatic frame(input logic [11:0] v);
    {done_seen, sample_seen} = 2'h0;
    analog_input_i = v;
    launch();
    wait_for(0, 1'b0, 400);
  endtask

  task automatic pop;
    result_ready_i = 1'b1;
    tick(1);
    result_ready_i = 1'b0;
  endtask

  task automatic abort_at(input int cyc, input logic exp_ab);
    ab_seen = 1'b0;
    launch();
    tick(30);
    check("awake", 16'(awake_o), 16'h0001);
    check("not full on", 16'(full_on_o), 16'h0000);
    tick(cyc - 30);
    check("full on", 16'(full_on_o), 16'h0001);
    abort_i = 1'b1;
    tick(1);
    abort_i = 1'b0;
    wait_for(0, 1'b0, 60);
    check("abort pulse", 16'(ab_seen), 16'(exp_ab));
    check("powered down", 16'(awake_o), 16'h0000);
    check("poisoned", 16'(invalid_o), 16'(exp_ab));
    check("no word", 16'(result_valid_o), 16'h0000);
    $display("test abort %0d done", cyc);
  endtask

  initial begin
    {resetn_i, start_i, abort_i, result_ready_i} = 4'h0;
    {done_seen, sample_seen, ab_seen} = 3'h0;
    analog_input_i = 12'h000;
    err_count = 0;
    tests_run = 0;
    tick(10);
    check("select idle", 16'(link.cs_n), 16'h0001);
    check("clock idle", 16'(link.sclk), 16'h0001);
    check("line released", 16'(link.sdo_line), 16'h0001);
    check("asleep", 16'(awake_o), 16'h0000);
    resetn_i = 1'b1;
    $display("test reset done");
    foreach (rows[i]) begin
      frame(rows[i].analog_input);
      check("word", {3'h0, result_valid_o, result_data_o}, rows[i].exp);
      check("sampled", 16'(sample_seen), 16'h0001);
      check("done", 16'(done_seen), 16'h0001);
      check("asleep", 16'(awake_o), 16'h0000);
      pop();
      $display("test row %0d done", i);
    end
    abort_at(140, 1'b1);
    frame(12'h777);
    check("discarded", 16'(result_valid_o), 16'h0000);
    check("poison cleared", 16'(invalid_o), 16'h0000);
    abort_at(159, 1'b0);
    frame(12'h456);
    check("word after abort", {3'h0, result_valid_o, result_data_o}, 16'h1456);
    pop();
    $display("test abort recovery done");
    repeat (FIFO_DEPTH) frame(12'h2b6);
    start_i = 1'b1;
    tick(4);
    check("full refuses", {14'h0, busy_o, start_ready_o}, 16'h0000);
    start_i = 1'b0;
    n = 0;
    result_ready_i = 1'b1;
    while (result_valid_o === 1'b1 && n < 40) begin
      check("fifo word", 16'(result_data_o), 16'h02b6);
      n++;
      tick(1);
    end
    result_ready_i = 1'b0;
    check("fifo count", 16'(n), 16'(FIFO_DEPTH));
    $display("test fifo done");
    // Reset in mid-frame, then a clean frame
    analog_input_i = 12'h3c3;
    launch();
    tick(60);
    resetn_i = 1'b0;
    tick(2);
    check("reset select", 16'(link.cs_n), 16'h0001);
    check("reset clock", 16'(link.sclk), 16'h0001);
    check("reset line", 16'(link.sdo_line), 16'h0001);
    check("reset asleep", 16'(awake_o), 16'h0000);
    check("reset idle", {14'h0, busy_o, result_valid_o}, 16'h0000);
    resetn_i = 1'b1;
    frame(12'h3c3);
    check("word after reset", {3'h0, result_valid_o, result_data_o}, 16'h13c3);
    check("clean after reset", 16'(invalid_o), 16'h0000);
    pop();
    $display("test mid reset done");
    summarize();
  end
endmodule
`default_nettype wire
